// *** hw/dbspi_defines.svh ***
// shared constants of the burst-of-four sram pin interface
`ifndef DBSPI_DEFINES_SVH
`define DBSPI_DEFINES_SVH

`define DBSPI_DQ_W 36
`define DBSPI_X18_W 18
`define DBSPI_ADDR_W 19
`define DBSPI_MEM_AW 6
`define DBSPI_BURST_LEN 4
`define DBSPI_BEAT_W 2
`define DBSPI_FIFO_DEPTH 32
`define DBSPI_LOCK_CYCLES 2048
`define DBSPI_RD_LAT_DLL_ON 3'h5
`define DBSPI_RD_LAT_DLL_OFF 3'h2
`define DBSPI_WR_LAT 2
`define DBSPI_RD_DLY_W 6
`define DBSPI_WR_DLY_W 2

`endif

// *** hw/dbspi_pkg.sv ***
// types of the burst-of-four sram pin interface
package dbspi_pkg;

   typedef enum logic [2:0] {
      RD_IDLE = 3'h0,
      RD_B0 = 3'h1,
      RD_B1 = 3'h3,
      RD_B2 = 3'h2,
      RD_B3 = 3'h6
   } dbspi_rd_e;

   typedef logic [1:0] dbspi_beat_t;

endpackage

// *** hw/dbspi_fifo.sv ***
// write beat buffer between the pin side and the storage array
`timescale 1ns/1ns
module dbspi_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 32
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // fill side
   input wire logic in_valid,
   input wire logic [W-1:0] in_data,
   output logic in_ready,
   // drain side
   output logic out_valid,
   output logic [W-1:0] out_data,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem_ff [DEPTH];
   logic [AW-1:0] wptr_ff;
   logic [AW-1:0] rptr_ff;
   logic [AW:0] cnt_ff;
   logic push;
   logic pop;

   assign in_ready = cnt_ff != (AW+1)'(DEPTH);
   assign out_valid = cnt_ff != '0;
   assign out_data = mem_ff[rptr_ff];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // depth is a power of two, so the pointers wrap on their own
   always_ff @(posedge clk) begin
      if (rst) begin
         wptr_ff <= '0;
         rptr_ff <= '0;
         cnt_ff <= '0;
      end else begin
         if (push) begin
            wptr_ff <= wptr_ff + 1'b1;
         end
         if (pop) begin
            rptr_ff <= rptr_ff + 1'b1;
         end
         cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem_ff[wptr_ff] <= in_data;
      end
   end

endmodule

// *** hw/dbspi_top.sv ***
// pin interface of a ddr burst-of-four common-io sram
//
// Contract
// - address and control taken on true clock rise
// - data taken on both input clock rises
// - echo clocks run free, even when idle
// - echo edges aligned with read data
// - bypass low resets dll lock state
// - bypass high locks dll after lock time
// - dll off gives one cycle read latency
// - output valid marks read data, echo aligned
// - address ignored while deselected
// - read data driven on data pins
// - narrow build uses data lines 0 to 17
// - direction input selects read or write
// - every access is four beats
// - first read beat two and half cycles later with dll on
// - idle cycle never cuts a read burst
`timescale 1ns/1ns
`include "dbspi_defines.svh"
module dbspi_top
   import dbspi_pkg::*;
#(
   parameter int DQ_W = `DBSPI_DQ_W,
   parameter bit WIDE = 1'b1,
   parameter int ADDR_W = `DBSPI_ADDR_W,
   parameter int MEM_AW = `DBSPI_MEM_AW,
   parameter int LOCK_CYCLES = `DBSPI_LOCK_CYCLES,
   parameter int FIFO_DEPTH = `DBSPI_FIFO_DEPTH
) (
   // system
   input wire logic SYS_CLK,
   input wire logic RST,
   // input clock pair
   input wire logic K_TRUE,
   input wire logic K_COMP,
   // command
   input wire logic LOAD_STROBE_N,
   input wire logic READ_NOT_WRITE,
   input wire logic [ADDR_W-1:0] ADDRESS_IN_BUS,
   input wire logic DLL_RUN,
   // shared data pins
   input wire logic [DQ_W-1:0] DQ_IN,
   output logic [DQ_W-1:0] DQ_OUT,
   output logic [DQ_W-1:0] DQ_OE,
   // echo and status
   output logic ECHO_OUT_TRUE,
   output logic ECHO_OUT_COMP,
   output logic OUTPUT_VALID,
   output logic DLL_LOCKED,
   output logic WRITE_BUF_READY
);
   localparam int IW = MEM_AW + `DBSPI_BEAT_W;
   localparam int FW = IW + DQ_W;
   localparam int CW = ADDR_W + 3;
   localparam int LCW = $clog2(LOCK_CYCLES + 1);

   // unused upper lines of the narrow build stay at zero
   function automatic logic [DQ_W-1:0] dq_mask(input logic [DQ_W-1:0] v);
      logic [DQ_W-1:0] m;
      m = '1;
      if (!WIDE) begin
         m = DQ_W'({`DBSPI_X18_W{1'b1}});
      end
      return v & m;
   endfunction

   function automatic logic [IW-1:0] mem_idx(input logic [ADDR_W-1:0] a,
                                             input dbspi_beat_t b);
      return {a[MEM_AW-1:0], b};
   endfunction

   logic k_m_ff, k_s_ff, k_d_ff;
   logic kb_m_ff, kb_s_ff, kb_d_ff;
   logic [CW-1:0] cmd_m_ff, cmd_s_ff;
   logic [DQ_W-1:0] dq_m_ff, dq_s_ff;
   logic k_rise, kb_rise, half;
   logic ld_n_s, rw_s, dll_run_s;
   logic [ADDR_W-1:0] addr_s;
   logic rd_cmd, wr_cmd;

   // every pin passes two flops before use
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         k_m_ff <= 1'b0;
         k_s_ff <= 1'b0;
         k_d_ff <= 1'b0;
         kb_m_ff <= 1'b0;
         kb_s_ff <= 1'b0;
         kb_d_ff <= 1'b0;
      end else begin
         k_m_ff <= K_TRUE;
         k_s_ff <= k_m_ff;
         k_d_ff <= k_s_ff;
         kb_m_ff <= K_COMP;
         kb_s_ff <= kb_m_ff;
         kb_d_ff <= kb_s_ff;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         cmd_m_ff <= {1'b1, {(CW-1){1'b0}}};
         cmd_s_ff <= {1'b1, {(CW-1){1'b0}}};
         dq_m_ff <= '0;
         dq_s_ff <= '0;
      end else begin
         cmd_m_ff <= {LOAD_STROBE_N, READ_NOT_WRITE, DLL_RUN,
                      ADDRESS_IN_BUS};
         cmd_s_ff <= cmd_m_ff;
         dq_m_ff <= DQ_IN;
         dq_s_ff <= dq_m_ff;
      end
   end

   assign {ld_n_s, rw_s, dll_run_s, addr_s} = cmd_s_ff;
   assign k_rise = k_s_ff && !k_d_ff;
   assign kb_rise = kb_s_ff && !kb_d_ff;
   assign half = k_rise || kb_rise;
   assign rd_cmd = k_rise && !ld_n_s && rw_s;
   assign wr_cmd = k_rise && !ld_n_s && !rw_s;

   // dll model: lock counter on true clock rises
   logic [LCW-1:0] lock_cnt_ff;
   logic locked_ff;

   always_ff @(posedge SYS_CLK) begin
      if (RST || !dll_run_s) begin
         lock_cnt_ff <= '0;
         locked_ff <= 1'b0;
      end else if (k_rise && !locked_ff) begin
         lock_cnt_ff <= lock_cnt_ff + 1'b1;
         locked_ff <= lock_cnt_ff == LCW'(LOCK_CYCLES - 1);
      end
   end
   assign DLL_LOCKED = locked_ff;

   // read scheduling in half cycles of the input clock
   logic [`DBSPI_RD_DLY_W-1:0] rd_dly_ff;
   logic [ADDR_W-1:0] rd_aq_ff [2];
   logic rd_wp_ff, rd_rp_ff;
   logic [ADDR_W-1:0] rd_base_ff;
   dbspi_rd_e rd_state_ff, nxt_rd_state;
   logic [2:0] rd_lat;
   logic rd_start, rd_drive;
   dbspi_beat_t rd_beat;
   logic [ADDR_W-1:0] rd_addr;

   // first beat after five half cycles with the dll on, two with it off
   assign rd_lat = dll_run_s ? `DBSPI_RD_LAT_DLL_ON : `DBSPI_RD_LAT_DLL_OFF;
   assign rd_start = half && rd_dly_ff[rd_lat - 3'h1];
   assign rd_addr = rd_start ? rd_aq_ff[rd_rp_ff] : rd_base_ff;

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         rd_dly_ff <= '0;
         rd_wp_ff <= 1'b0;
         rd_rp_ff <= 1'b0;
         rd_base_ff <= '0;
         rd_aq_ff[0] <= '0;
         rd_aq_ff[1] <= '0;
      end else begin
         if (half) begin
            rd_dly_ff <= {rd_dly_ff[`DBSPI_RD_DLY_W-2:0], rd_cmd};
         end
         if (rd_cmd) begin
            rd_aq_ff[rd_wp_ff] <= addr_s;
            rd_wp_ff <= !rd_wp_ff;
         end
         if (rd_start) begin
            rd_base_ff <= rd_aq_ff[rd_rp_ff];
            rd_rp_ff <= !rd_rp_ff;
         end
      end
   end

   always_comb begin
      nxt_rd_state = rd_state_ff;
      rd_beat = 2'h0;
      rd_drive = 1'b0;
      if (half) begin
         case (rd_state_ff)
            RD_B0: begin
               nxt_rd_state = RD_B1;
               rd_beat = 2'h1;
               rd_drive = 1'b1;
            end
            RD_B1: begin
               nxt_rd_state = RD_B2;
               rd_beat = 2'h2;
               rd_drive = 1'b1;
            end
            RD_B2: begin
               nxt_rd_state = RD_B3;
               rd_beat = 2'h3;
               rd_drive = 1'b1;
            end
            default: begin
               nxt_rd_state = RD_IDLE;
               if (rd_start) begin
                  nxt_rd_state = RD_B0;
                  rd_drive = 1'b1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         rd_state_ff <= RD_IDLE;
      end else begin
         rd_state_ff <= nxt_rd_state;
      end
   end

   // storage array, written only from the buffer
   logic [DQ_W-1:0] mem_ff [2**IW];
   logic [DQ_W-1:0] dq_out_ff, dq_oe_ff;
   logic valid_ff, echo_t_ff, echo_c_ff;

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         dq_out_ff <= '0;
         dq_oe_ff <= '0;
         valid_ff <= 1'b0;
      end else if (half) begin
         valid_ff <= rd_drive;
         dq_oe_ff <= rd_drive ? dq_mask('1) : '0;
         if (rd_drive) begin
            dq_out_ff <= dq_mask(mem_ff[mem_idx(rd_addr, rd_beat)]);
         end
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         echo_t_ff <= 1'b0;
         echo_c_ff <= 1'b0;
      end else begin
         echo_t_ff <= k_s_ff;
         echo_c_ff <= kb_s_ff;
      end
   end

   assign DQ_OUT = dq_out_ff;
   assign DQ_OE = dq_oe_ff;
   assign OUTPUT_VALID = valid_ff;
   assign ECHO_OUT_TRUE = echo_t_ff;
   assign ECHO_OUT_COMP = echo_c_ff;

   // late write: beats start one cycle after the command
   logic [`DBSPI_WR_DLY_W-1:0] wr_dly_ff;
   logic [ADDR_W-1:0] wr_cmd_addr_ff, wr_base_ff;
   dbspi_beat_t wr_beat_ff;
   logic wr_act_ff, wr_start, wr_push;
   logic [FW-1:0] wr_word, fifo_word;
   logic fifo_in_ready, fifo_out_valid, fifo_out_ready;

   assign wr_start = half && wr_dly_ff[`DBSPI_WR_LAT-1];
   assign wr_push = half && (wr_start || wr_act_ff);
   assign wr_word = wr_start
      ? {mem_idx(wr_cmd_addr_ff, 2'h0), dq_mask(dq_s_ff)}
      : {mem_idx(wr_base_ff, wr_beat_ff), dq_mask(dq_s_ff)};

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         wr_dly_ff <= '0;
         wr_cmd_addr_ff <= '0;
         wr_base_ff <= '0;
         wr_beat_ff <= 2'h0;
         wr_act_ff <= 1'b0;
      end else begin
         if (half) begin
            wr_dly_ff <= {wr_dly_ff[`DBSPI_WR_DLY_W-2:0], wr_cmd};
         end
         if (wr_cmd) begin
            wr_cmd_addr_ff <= addr_s;
         end
         if (wr_start) begin
            wr_base_ff <= wr_cmd_addr_ff;
            wr_beat_ff <= 2'h1;
            wr_act_ff <= 1'b1;
         end else if (wr_push) begin
            wr_beat_ff <= wr_beat_ff + 2'h1;
            wr_act_ff <= wr_beat_ff != 2'h3;
         end
      end
   end

   // draining pauses on pin edges so a read fetch sees a quiet array
   assign fifo_out_ready = !half;

   dbspi_fifo #(
      .W(FW),
      .DEPTH(FIFO_DEPTH)
   ) u_wr_buf (
      .clk(SYS_CLK),
      .rst(RST),
      .in_valid(wr_push),
      .in_data(wr_word),
      .in_ready(fifo_in_ready),
      .out_valid(fifo_out_valid),
      .out_data(fifo_word),
      .out_ready(fifo_out_ready)
   );

   always_ff @(posedge SYS_CLK) begin
      if (fifo_out_valid && fifo_out_ready) begin
         mem_ff[fifo_word[FW-1:DQ_W]] <= fifo_word[DQ_W-1:0];
      end
   end

   // a beat offered while full is lost; the port lets a system see it
   assign WRITE_BUF_READY = fifo_in_ready;

   // checks
   logic [3:0] vbeat_ff;
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         vbeat_ff <= 4'h0;
      end else if (half && rd_drive) begin
         vbeat_ff <= valid_ff ? vbeat_ff + 4'h1 : 4'h1;
      end
   end

   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RST);

   AST_CMD_ON_TRUE_RISE: assert property (
      (rd_cmd || wr_cmd) |-> k_s_ff && !k_d_ff && !kb_rise)
      else $error("command taken off the true clock rise");
   AST_WR_BEAT_EDGE: assert property (
      wr_push |-> (k_s_ff && !k_d_ff) || (kb_s_ff && !kb_d_ff))
      else $error("write beat taken off a clock rise");
   AST_ECHO_FREE_RUN: assert property (
      $rose(k_s_ff) |=> $rose(ECHO_OUT_TRUE))
      else $error("echo clock did not follow input clock");
   AST_VALID_ON_ECHO: assert property (
      $changed(OUTPUT_VALID) |->
         $changed(ECHO_OUT_TRUE) || $changed(ECHO_OUT_COMP))
      else $error("valid changed away from an echo edge");
   AST_DATA_ON_ECHO: assert property (
      $changed(DQ_OUT) |-> $changed(ECHO_OUT_TRUE) || $changed(ECHO_OUT_COMP))
      else $error("read data changed away from an echo edge");
   AST_DLL_BYPASS_RESET: assert property (
      !dll_run_s |=> lock_cnt_ff == '0 && !DLL_LOCKED)
      else $error("lock state kept while bypassed");
   AST_DLL_LOCK_TIME: assert property (
      $rose(DLL_LOCKED) |-> $past(lock_cnt_ff) == LCW'(LOCK_CYCLES - 1))
      else $error("dll locked at the wrong count");
   AST_DLL_OFF_LATENCY: assert property (
      (rd_cmd && !dll_run_s && rd_state_ff == RD_IDLE && rd_dly_ff == '0)
         ##1 (!dll_run_s)[*8] |-> ##[1:16] $rose(OUTPUT_VALID))
      else $error("dll off read latency wrong");
   AST_DESELECT_IGNORED: assert property (
      (k_rise && ld_n_s) |-> !rd_cmd && !wr_cmd)
      else $error("address taken while deselected");
   AST_READ_DRIVES: assert property (
      OUTPUT_VALID |-> DQ_OE == dq_mask('1))
      else $error("read beat not driven on data pins");
   AST_NARROW_LINES: assert property (
      !WIDE |-> (DQ_OE & ~dq_mask('1)) == '0)
      else $error("unused data line driven");
   AST_FOUR_BEATS: assert property (
      $fell(OUTPUT_VALID) |-> vbeat_ff[1:0] == 2'h0 && vbeat_ff != 4'h0)
      else $error("read burst not a multiple of four beats");
   AST_NOP_NO_CUT: assert property (
      (half && rd_state_ff == RD_B1 && ld_n_s) |=> rd_state_ff == RD_B2)
      else $error("idle cycle cut a read burst");
   AST_FIRST_BEAT_COMP: assert property (
      (half && rd_start && dll_run_s && rd_state_ff == RD_IDLE)
         |-> kb_rise)
      else $error("first read beat not on complementary rise");

   COV_READ_BURST: cover property ($fell(OUTPUT_VALID) && vbeat_ff == 4'h4);
   COV_BACK_TO_BACK: cover property (OUTPUT_VALID && vbeat_ff == 4'h8);
   COV_WRITE_BURST: cover property (wr_push && wr_beat_ff == 2'h3);
   COV_DLL_LOCK: cover property ($rose(DLL_LOCKED));

endmodule

// *** sim/dbspi_host.sv ***
// host-side model: input clock pair, commands and write data
`timescale 1ns/1ns
module dbspi_host #(
   parameter int ADDR_W = 19,
   parameter int DQ_W = 36
) (
   // system clock used only to place pin changes
   input wire logic sys_clk,
   // input clock pair
   output logic k_true,
   output logic k_comp,
   // command pins
   output logic load_strobe_n,
   output logic read_not_write,
   output logic [ADDR_W-1:0] address_in_bus,
   // host side of the shared data pins
   output logic [DQ_W-1:0] dq_drv,
   output logic dq_en
);
   time cmd_time;

   // free-running 8 MHz pair, idle commands from time zero
   initial begin
      k_true = 1'b0;
      load_strobe_n = 1'b1;
      read_not_write = 1'b1;
      address_in_bus = '0;
      dq_en = 1'b0;
      dq_drv = '0;
      // offset keeps every input clock edge clear of a system clock edge
      #2;
      forever begin
         #62 k_true = 1'b1;
         #63 k_true = 1'b0;
      end
   end
   // complement is the inverse, rising 63 ns after each true rise
   assign k_comp = ~k_true;

   // released bus keeps changing so no stale value looks valid
   always @(posedge sys_clk) begin
      if (!dq_en) begin
         dq_drv <= ~dq_drv;
      end
   end

   // pins change midway between rises, clear of both sampling edges
   task automatic after_rise(input logic comp);
      if (comp) begin
         @(posedge k_comp);
      end else begin
         @(posedge k_true);
      end
      #26;
      @(negedge sys_clk);
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge k_true);
   endtask

   // load low with direction and address for one true rise
   task automatic command(input logic rnw, input logic [ADDR_W-1:0] a);
      after_rise(1'b1);
      load_strobe_n = 1'b0;
      read_not_write = rnw;
      address_in_bus = a;
      @(posedge k_true);
      cmd_time = $time;
      #26;
      @(negedge sys_clk);
      load_strobe_n = 1'b1;
      address_in_bus = ~a;
   endtask

   // four beats from the next true rise, then release
   task automatic write_burst(input logic [ADDR_W-1:0] a,
                              input logic [3:0][DQ_W-1:0] d);
      command(1'b0, a);
      for (int i = 0; i < 4; i++) begin
         after_rise(i[0] ? 1'b0 : 1'b1);
         dq_en = 1'b1;
         dq_drv = d[i];
      end
      after_rise(1'b1);
      dq_en = 1'b0;
   endtask
endmodule

// *** sim/dbspi_top_tb.sv ***
// self-checking bench of the burst-of-four sram pin interface
`timescale 1ns/1ns
module dbspi_top_tb
   import dbspi_pkg::*;
;
   // short lock count keeps the run brief
   localparam int LOCK = 8;
   logic sys_clk, rst, k_true, k_comp, load_strobe_n, read_not_write;
   logic dll_run, dq_en, echo_t, echo_c, output_valid, dll_locked;
   logic wbuf_ready, echo_prev, valid_prev;
   logic [18:0] address_in_bus;
   logic [35:0] dq_drv, dq_wire, dq_out, dq_oe;
   logic [35:0] mem [logic [7:0]];
   logic [35:0] got [$];
   logic [35:0] exp_q [$];
   logic [18:0] adr [6];
   int miscompares = 0;
   int tests_run = 0;
   int seed = 32'hEC03B123;
   int cycles = 0;
   int echo_cnt = 0;
   int echoc_cnt = 0;
   logic echoc_prev = 1'b0;
   time valid_rise;

   dbspi_host host (.sys_clk(sys_clk), .k_true(k_true), .k_comp(k_comp),
      .load_strobe_n(load_strobe_n), .read_not_write(read_not_write),
      .address_in_bus(address_in_bus), .dq_drv(dq_drv), .dq_en(dq_en));

   dbspi_top #(.LOCK_CYCLES(LOCK)) uut (.SYS_CLK(sys_clk), .RST(rst),
      .K_TRUE(k_true), .K_COMP(k_comp), .LOAD_STROBE_N(load_strobe_n),
      .READ_NOT_WRITE(read_not_write), .ADDRESS_IN_BUS(address_in_bus),
      .DLL_RUN(dll_run), .DQ_IN(dq_wire), .DQ_OUT(dq_out), .DQ_OE(dq_oe),
      .ECHO_OUT_TRUE(echo_t), .ECHO_OUT_COMP(echo_c),
      .OUTPUT_VALID(output_valid), .DLL_LOCKED(dll_locked),
      .WRITE_BUF_READY(wbuf_ready));

   // each data line carries whichever party enables it
   assign dq_wire = (dq_oe & dq_out) | (~dq_oe & dq_drv);

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   task automatic check(input logic [35:0] seen, input logic [35:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // a hung handshake ends the run as a failure
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 30000) begin
         miscompares++;
         print_verdict();
      end
   end

   // sampled mid-cycle, where the registered outputs have settled
   always @(negedge sys_clk) begin
      if (echo_t !== echo_prev) begin
         echo_cnt++;
      end
      if (echo_c !== echoc_prev) begin
         echoc_cnt++;
      end
      // device must not drive while the host owns the data pins
      if (dq_en === 1'b1) begin
         check(dq_oe, 36'h0);
      end
      // a beat is taken at each echo edge while valid
      if (output_valid === 1'b1 && echo_t !== echo_prev) begin
         got.push_back(dq_out);
         check(dq_oe, 36'hFFFFFFFFF);
      end
      if (output_valid === 1'b1 && valid_prev !== 1'b1) begin
         valid_rise = $time;
      end
      echo_prev = echo_t;
      echoc_prev = echo_c;
      valid_prev = output_valid;
   end

   task automatic expect_read(input logic [18:0] a);
      for (int n = 0; n < 4; n++) begin
         exp_q.push_back(mem[{a[5:0], 2'(n)}]);
      end
   endtask

   task automatic drain_check();
      int i;
      i = 0;
      while (got.size() < exp_q.size() && i < 400) begin
         @(negedge sys_clk);
         i++;
      end
      // a short quiet spell shows up any extra beat
      repeat (20) @(negedge sys_clk);
      check(36'(got.size()), 36'(exp_q.size()));
      foreach (exp_q[j]) if (j < got.size()) check(got[j], exp_q[j]);
      got.delete();
      exp_q.delete();
   endtask

   task automatic wr(input logic [18:0] a);
      logic [3:0][35:0] d;
      for (int n = 0; n < 4; n++) begin
         d[n] = 36'({$random(seed), $random(seed)});
         mem[{a[5:0], 2'(n)}] = d[n];
      end
      host.write_burst(a, d);
      check(36'(wbuf_ready), 36'h1);
   endtask

   task automatic rd(input logic [18:0] a, input int halves);
      int lo;
      longint lat;
      lo = halves * 125 / 2 + 20;
      host.command(1'b1, a);
      expect_read(a);
      drain_check();
      lat = longint'(valid_rise - host.cmd_time);
      check(36'(lat >= lo && lat <= lo + 30), 36'h1);
   endtask

   initial begin
      rst = 1'b1;
      dll_run = 1'b0;
      echo_prev = 1'b0;
      valid_prev = 1'b0;
      repeat (5) @(posedge sys_clk);
      @(negedge sys_clk);
      rst = 1'b0;
      host.idle(4);
      check(36'(dll_locked), 36'h0);
      // echoes toggle on every half edge while idle
      echo_cnt = 0;
      echoc_cnt = 0;
      host.idle(10);
      check(36'(echo_cnt >= 19 && echo_cnt <= 21), 36'h1);
      check(36'(echoc_cnt >= 19 && echoc_cnt <= 21), 36'h1);
      // corner addresses first, then random ones
      adr[0] = 19'h00000;
      adr[1] = 19'h7FFFF;
      for (int i = 2; i < 6; i++) adr[i] = 19'($random(seed));
      // writes then reads in bypass mode, one cycle latency
      foreach (adr[i]) wr(adr[i]);
      foreach (adr[i]) rd(adr[i], 2);
      // lock only after the lock count
      @(negedge sys_clk);
      dll_run = 1'b1;
      host.idle(LOCK - 2);
      check(36'(dll_locked), 36'h0);
      host.idle(4);
      check(36'(dll_locked), 36'h1);
      foreach (adr[i]) rd(adr[i], 5);
      // back-to-back reads with one nop between, no burst cut
      host.command(1'b1, adr[2]);
      host.idle(1);
      host.command(1'b1, adr[3]);
      expect_read(adr[2]);
      expect_read(adr[3]);
      drain_check();
      // overwrite, then read back in both latency modes
      wr(adr[1]);
      rd(adr[1], 5);
      @(negedge sys_clk);
      dll_run = 1'b0;
      host.idle(3);
      check(36'(dll_locked), 36'h0);
      rd(adr[1], 2);
      print_verdict();
   end
endmodule
